// ===== src/two_cell_protection_fsm.sv
// Protection state logic for a two-cell lithium pack: fault latches and FET gates
`timescale 1ns/1ps
// How it works
// (R1) Either cell under-voltage for detect delay turns discharge gate off.
// (R2) Over-discharge with charger clears once pack supply rises above threshold.
// (R3) Charger attached with both cells above threshold clears over-discharge at once.
// (R4) Hysteresis option releases over-discharge when both cells reach release voltage.
// (R5) Cell at zero volts: charge gate on when charger meets zero-volt minimum.
// (R6) Over-discharge needs condition held for full delay; early recovery cancels it.
// (R7) Over-discharge release waits its own fixed delay.
// (R8) Over-discharge latched raises the standby request.
// (R9) Excess discharge and short detection run only with both gates on.
// (R10) Load pin above current or short threshold starts matching path; gate off.
// (R11) Early recovery below excess-current threshold keeps gate on; release has delay.
// (R12) Short path turns discharge off after its own shorter delay.
// (R13) Load-pin pull-down on only while excess discharge or short is latched.
// (R14) Load pin back near ground after fault turns discharge gate on again.
// (R15) Excess-current delay shorter than over-discharge; together ends in excess-current.
// (R16) Both gates on and load pin low: excess charge turns charge gate off.
// (R17) Excess charge detection filtered by delay; release has its own delay.
// (R18) Excess charge clears only with charger removed and load connected.
// (R19) Charge gate on and test voltage present shortens over-charge/discharge delays.
// (R20) Options A and B: latched over-charge keeps charge gate off regardless.
// (R21) Option A: over-discharge may follow over-charge; each output on its own delay.
// (R22) Option B: latched over-discharge holds even if other cell over-charges.
// (R23) Either cell over-voltage for detect delay latches over-charge; charge gate off.
// (R24) Excess discharge: 12 ms detect, 1.2 ms release.
// (R25) Short circuit: 300 us detect.
// (R26) Excess charge: 8 ms detect, 1.2 ms release.
// (R27) Every delay is a counter that restarts when its condition drops.
// (R28) Comparator inputs pass a two-flop synchroniser first.
module two_cell_protection_fsm
  import prot_pkg::*;
#(
  parameter int OC_DET_CYC  = CYC_OC_DET,
  parameter int OC_REL_CYC  = CYC_OC_REL,
  parameter int OD_DET_CYC  = CYC_OD_DET,
  parameter int OD_REL_CYC  = CYC_OD_REL,
  parameter int EDC_DET_CYC = CYC_EDC_DET,
  parameter int EDC_REL_CYC = CYC_EDC_REL,
  parameter int SC_DET_CYC  = CYC_SC_DET,
  parameter int ECC_DET_CYC = CYC_ECC_DET,
  parameter int ECC_REL_CYC = CYC_ECC_REL,
  parameter int DS_DIV      = DS_DIV_DEF
) (
  input  wire logic      core_clk,
  input  wire logic      reset,
  input  wire pin_in_t   pins_in,
  output gate_out_t      gates_out
);

  // Elaboration checks: every count must fit the counters and be nonzero
  localparam int TMAX = (1 << TW) - 1;

  generate
    if (OC_DET_CYC < 1 || OC_DET_CYC > TMAX) begin : g_bad_oc_det
      $error("OC_DET_CYC out of range");
    end
    if (OC_REL_CYC < 1 || OC_REL_CYC > TMAX) begin : g_bad_oc_rel
      $error("OC_REL_CYC out of range");
    end
    if (OD_DET_CYC < 1 || OD_DET_CYC > TMAX) begin : g_bad_od_det
      $error("OD_DET_CYC out of range");
    end
    if (OD_REL_CYC < 1 || OD_REL_CYC > TMAX) begin : g_bad_od_rel
      $error("OD_REL_CYC out of range");
    end
    if (EDC_DET_CYC < 1 || EDC_DET_CYC > TMAX) begin : g_bad_edc_det
      $error("EDC_DET_CYC out of range");
    end
    if (EDC_REL_CYC < 1 || EDC_REL_CYC > TMAX) begin : g_bad_edc_rel
      $error("EDC_REL_CYC out of range");
    end
    if (SC_DET_CYC < 1 || SC_DET_CYC >= EDC_DET_CYC) begin : g_bad_sc_det
      $error("SC_DET_CYC must be nonzero and below EDC_DET_CYC");
    end
    if (ECC_DET_CYC < 1 || ECC_DET_CYC > TMAX) begin : g_bad_ecc_det
      $error("ECC_DET_CYC out of range");
    end
    if (ECC_REL_CYC < 1 || ECC_REL_CYC > TMAX) begin : g_bad_ecc_rel
      $error("ECC_REL_CYC out of range");
    end
    if (EDC_DET_CYC >= OD_DET_CYC) begin : g_bad_order
      $error("EDC_DET_CYC must be below OD_DET_CYC");                // R15
    end
    if (DS_DIV < 1) begin : g_bad_div
      $error("DS_DIV must be at least 1");
    end
  endgenerate

  // Full and shortened limits, shortened ones never below one cycle
  localparam logic [TW-1:0] L_OC_DET  = TW'(OC_DET_CYC);
  localparam logic [TW-1:0] L_OC_REL  = TW'(OC_REL_CYC);
  localparam logic [TW-1:0] L_OD_DET  = TW'(OD_DET_CYC);
  localparam logic [TW-1:0] L_OD_REL  = TW'(OD_REL_CYC);
  localparam logic [TW-1:0] S_OC_DET  = TW'((OC_DET_CYC / DS_DIV) > 0 ? OC_DET_CYC / DS_DIV : 1);
  localparam logic [TW-1:0] S_OC_REL  = TW'((OC_REL_CYC / DS_DIV) > 0 ? OC_REL_CYC / DS_DIV : 1);
  localparam logic [TW-1:0] S_OD_DET  = TW'((OD_DET_CYC / DS_DIV) > 0 ? OD_DET_CYC / DS_DIV : 1);
  localparam logic [TW-1:0] S_OD_REL  = TW'((OD_REL_CYC / DS_DIV) > 0 ? OD_REL_CYC / DS_DIV : 1);
  localparam logic [TW-1:0] L_EDC_DET = TW'(EDC_DET_CYC);
  localparam logic [TW-1:0] L_EDC_REL = TW'(EDC_REL_CYC);
  localparam logic [TW-1:0] L_SC_DET  = TW'(SC_DET_CYC);
  localparam logic [TW-1:0] L_ECC_DET = TW'(ECC_DET_CYC);
  localparam logic [TW-1:0] L_ECC_REL = TW'(ECC_REL_CYC);

  // Module state: latched faults and registered outputs
  typedef struct packed {
    fault_t    fault;
    gate_out_t gates;
  } prot_state_t;

  prot_state_t state_reg;
  prot_state_t state_next;

  pin_in_t       pin_s;
  logic          shorten;
  version_t      version;
  logic          any_uv;
  logic          any_ov;
  logic          both_on;
  logic          load_seen;
  logic          ab_option;
  logic [NTIMERS-1:0] tcond;
  logic [NTIMERS-1:0] tdone;
  logic [TW-1:0]      tlim [NTIMERS];

  // Comparator levels come from the analog domain
  cond_sync #(
    .WIDTH ($bits(pin_in_t))
  ) u_sync (
    .core_clk (core_clk),
    .reset    (reset),
    .async_in (pins_in),
    .sync_out (pin_s)                                            // R28
  );

  // Decoded levels used across the state logic
  always_comb begin
    version   = version_t'(pin_s.version_sel);
    ab_option = (version == VER_A) || (version == VER_B);
    any_uv    = pin_s.upper_cell_underv_detector | pin_s.lower_cell_underv_detector;
    any_ov    = pin_s.upper_cell_overv_detector | pin_s.lower_cell_overv_detector;
    both_on   = state_reg.gates.charge_gate_on & state_reg.gates.discharge_gate_on;
    // A load lifts the load pin over the excess-current threshold
    load_seen = pin_s.discharge_overcurrent_detector;
    // Test mode only counts while the charge gate is on
    shorten   = state_reg.gates.charge_gate_on & pin_s.delay_shorten_test;   // R19
  end

  // Conditions each delay filter watches; a filter restarts when its condition drops
  always_comb begin
    tcond = '0;
    // Over-charge detect and release
    tcond[TI_OC_DET] = !state_reg.fault.overcharge && any_ov;                      // R23
    tcond[TI_OC_REL] = state_reg.fault.overcharge && !any_ov
                       && !pin_s.charger_present && load_seen;
    // Over-discharge: held off while a current fault owns the discharge gate
    tcond[TI_OD_DET] = !state_reg.fault.overdischarge && any_uv                    // R6
                       && !state_reg.fault.excess_discharge                        // R15
                       && !state_reg.fault.short_circuit
                       && (!state_reg.fault.overcharge || version == VER_A);       // R21
    tcond[TI_OD_REL] = state_reg.fault.overdischarge
                       && ((pin_s.charger_present && pin_s.pack_above_underv)      // R2
                           || (version == VER_A && pin_s.upper_cell_release_ok
                               && pin_s.lower_cell_release_ok))                    // R4
                       && !(version == VER_B && any_ov);                           // R22
    // Discharge-current detect paths only armed with both gates on
    tcond[TI_EDC_DET] = both_on && pin_s.discharge_overcurrent_detector            // R9
                        && !pin_s.short_detector;                                  // R10
    tcond[TI_SC_DET]  = both_on && pin_s.short_detector;                           // R12
    tcond[TI_EDC_REL] = (state_reg.fault.excess_discharge
                         || state_reg.fault.short_circuit)
                        && !pin_s.discharge_overcurrent_detector;                  // R14
    // Excess charge current
    tcond[TI_ECC_DET] = both_on && pin_s.charge_overcurrent_detector;              // R16
    tcond[TI_ECC_REL] = state_reg.fault.excess_charge
                        && !pin_s.charger_present && load_seen;                    // R18
  end

  // Limits; only the over-charge and over-discharge delays shrink in test mode
  always_comb begin
    tlim[TI_OC_DET]  = shorten ? S_OC_DET : L_OC_DET;                 // R19
    tlim[TI_OC_REL]  = shorten ? S_OC_REL : L_OC_REL;
    tlim[TI_OD_DET]  = shorten ? S_OD_DET : L_OD_DET;
    tlim[TI_OD_REL]  = shorten ? S_OD_REL : L_OD_REL;
    tlim[TI_EDC_DET] = L_EDC_DET;                                     // R24
    tlim[TI_EDC_REL] = L_EDC_REL;                                     // R24
    tlim[TI_SC_DET]  = L_SC_DET;                                      // R25
    tlim[TI_ECC_DET] = L_ECC_DET;                                     // R26
    tlim[TI_ECC_REL] = L_ECC_REL;                                     // R26
  end

  // One counter per delay
  generate
    for (genvar i = 0; i < NTIMERS; i++) begin : g_timer
      delay_timer u_timer (
        .core_clk (core_clk),
        .reset    (reset),
        .cond     (tcond[i]),                                        // R27
        .limit    (tlim[i]),
        .done     (tdone[i])
      );
    end
  endgenerate

  // Fault latches and gate outputs
  always_comb begin
    state_next = state_reg;

    // Over-charge latch
    if (tdone[TI_OC_DET]) begin
      state_next.fault.overcharge = 1'b1;                            // R23
    end else if (tdone[TI_OC_REL]) begin
      state_next.fault.overcharge = 1'b0;
    end

    // Over-discharge: timed detect, timed or immediate release
    if (tdone[TI_OD_DET]) begin
      state_next.fault.overdischarge = 1'b1;                         // R1
    end else if (state_reg.fault.overdischarge && pin_s.charger_present
                 && !any_uv && !(version == VER_B && any_ov)) begin
      state_next.fault.overdischarge = 1'b0;                         // R3
    end else if (tdone[TI_OD_REL]) begin
      state_next.fault.overdischarge = 1'b0;                         // R7
    end

    // Excess discharge and short share the release filter
    if (tdone[TI_SC_DET]) begin
      state_next.fault.short_circuit = 1'b1;                         // R12
    end else if (tdone[TI_EDC_REL]) begin
      state_next.fault.short_circuit = 1'b0;
    end
    if (tdone[TI_EDC_DET]) begin
      state_next.fault.excess_discharge = 1'b1;                      // R10
    end else if (tdone[TI_EDC_REL]) begin
      state_next.fault.excess_discharge = 1'b0;                      // R11
    end

    // Excess charge
    if (tdone[TI_ECC_DET]) begin
      state_next.fault.excess_charge = 1'b1;                         // R16
    end else if (tdone[TI_ECC_REL]) begin
      state_next.fault.excess_charge = 1'b0;                         // R17
    end

    // Charge gate: over-charge dominates in options A and B
    state_next.gates.charge_gate_on = !state_next.fault.overcharge
                                      && !state_next.fault.excess_charge;
    if (state_next.fault.overcharge && ab_option) begin
      state_next.gates.charge_gate_on = 1'b0;                        // R20
    end else if (pin_s.cell_at_zero) begin
      state_next.gates.charge_gate_on = pin_s.zero_charge_ok                // R5
                                        && !state_next.fault.excess_charge;
    end

    // Discharge gate off for any discharge-side fault
    state_next.gates.discharge_gate_on = !state_next.fault.overdischarge
                                         && !state_next.fault.excess_discharge
                                         && !state_next.fault.short_circuit;

    // Pull-down only while a current fault is latched
    state_next.gates.load_pulldown_on = state_next.fault.excess_discharge
                                        || state_next.fault.short_circuit;   // R13

    // Standby follows over-discharge
    state_next.gates.standby_req = state_next.fault.overdischarge;          // R8
  end

  // State register; synchronous reset to the no-fault state
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_reg.fault                   <= '{default: RST_FAULT};
      state_reg.gates.charge_gate_on    <= RST_GATE_ON;
      state_reg.gates.discharge_gate_on <= RST_GATE_ON;
      state_reg.gates.load_pulldown_on  <= RST_FAULT;
      state_reg.gates.standby_req       <= RST_FAULT;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from the state register
  assign gates_out = state_reg.gates;

endmodule : two_cell_protection_fsm

// ===== include/prot_pkg.sv
// Shared constants and carrier types for the two-cell protection state logic
package prot_pkg;

  // Core clock rate
  localparam real CLK_MHZ = 200.0;

  // Width of every delay counter and of every delay limit
  localparam int TW = 24;

  // Delay times in their own units, figures as printed
  localparam real T_EDC_DET_MS = 12.0;
  localparam real T_EDC_REL_MS = 1.2;
  localparam real T_SC_DET_US  = 300.0;
  localparam real T_ECC_DET_MS = 8.0;
  localparam real T_ECC_REL_MS = 1.2;
  // Plain defaults for delays whose typical value is not given here
  localparam real T_OC_DET_MS  = 1.0;
  localparam real T_OC_REL_MS  = 0.1;
  localparam real T_OD_DET_MS  = 20.0;
  localparam real T_OD_REL_MS  = 1.0;

  // Cycle counts derived from the times and the clock rate
  localparam int CYC_EDC_DET = int'(T_EDC_DET_MS * 1000.0 * CLK_MHZ);
  localparam int CYC_EDC_REL = int'(T_EDC_REL_MS * 1000.0 * CLK_MHZ);
  localparam int CYC_SC_DET  = int'(T_SC_DET_US * CLK_MHZ);
  localparam int CYC_ECC_DET = int'(T_ECC_DET_MS * 1000.0 * CLK_MHZ);
  localparam int CYC_ECC_REL = int'(T_ECC_REL_MS * 1000.0 * CLK_MHZ);
  localparam int CYC_OC_DET  = int'(T_OC_DET_MS * 1000.0 * CLK_MHZ);
  localparam int CYC_OC_REL  = int'(T_OC_REL_MS * 1000.0 * CLK_MHZ);
  localparam int CYC_OD_DET  = int'(T_OD_DET_MS * 1000.0 * CLK_MHZ);
  localparam int CYC_OD_REL  = int'(T_OD_REL_MS * 1000.0 * CLK_MHZ);

  // Divisor applied to shortenable delays in delay-shorten test mode
  localparam int DS_DIV_DEF = 16;

  // Timer slots
  localparam int TI_OC_DET  = 0;
  localparam int TI_OC_REL  = 1;
  localparam int TI_OD_DET  = 2;
  localparam int TI_OD_REL  = 3;
  localparam int TI_EDC_DET = 4;
  localparam int TI_EDC_REL = 5;
  localparam int TI_SC_DET  = 6;
  localparam int TI_ECC_DET = 7;
  localparam int TI_ECC_REL = 8;
  localparam int NTIMERS    = 9;

  // Values after reset: no fault, both FETs on
  localparam logic RST_GATE_ON = 1'b1;
  localparam logic RST_FAULT   = 1'b0;

  // Version options
  typedef enum logic [1:0] {VER_A, VER_B, VER_C, VER_D} version_t;

  // Comparator results and straps, all from the analog side
  typedef struct packed {
    logic       upper_cell_underv_detector;
    logic       lower_cell_underv_detector;
    logic       upper_cell_overv_detector;
    logic       lower_cell_overv_detector;
    logic       discharge_overcurrent_detector;
    logic       short_detector;
    logic       charge_overcurrent_detector;
    logic       delay_shorten_test;
    logic       charger_present;
    logic       pack_above_underv;
    logic       upper_cell_release_ok;
    logic       lower_cell_release_ok;
    logic       cell_at_zero;
    logic       zero_charge_ok;
    logic [1:0] version_sel;
  } pin_in_t;

  // Latched fault states
  typedef struct packed {
    logic overcharge;
    logic overdischarge;
    logic excess_discharge;
    logic short_circuit;
    logic excess_charge;
  } fault_t;

  // Gate and control outputs
  typedef struct packed {
    logic charge_gate_on;
    logic discharge_gate_on;
    logic load_pulldown_on;
    logic standby_req;
  } gate_out_t;

endpackage : prot_pkg

// ===== src/cond_sync.sv
// Two-flop synchroniser for a vector of asynchronous comparator levels
`timescale 1ns/1ps
module cond_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             core_clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  generate
    if (WIDTH < 1) begin : g_bad_width
      $error("cond_sync: WIDTH must be at least 1");
    end
  endgenerate

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_state_t;

  sync_state_t state_reg;
  sync_state_t state_next;

  // First stage feeds only the second stage
  always_comb begin
    state_next        = state_reg;
    state_next.meta   = async_in;
    state_next.stable = state_reg.meta;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign sync_out = state_reg.stable;

endmodule : cond_sync

// ===== src/delay_timer.sv
// Persistence filter: pulses once a condition has held for a set number of cycles
`timescale 1ns/1ps
module delay_timer
  import prot_pkg::*;
(
  input  wire logic          core_clk,
  input  wire logic          reset,
  input  wire logic          cond,
  input  wire logic [TW-1:0] limit,
  output logic               done
);

  typedef struct packed {
    logic [TW-1:0] count;
    logic          done;
  } timer_state_t;

  timer_state_t state_reg;
  timer_state_t state_next;

  // Any drop of the condition restarts the count
  always_comb begin
    state_next      = state_reg;
    state_next.done = 1'b0;
    if (!cond) begin
      state_next.count = '0;
    end else if (state_reg.count >= limit - TW'(1)) begin
      state_next.done  = 1'b1;
      state_next.count = '0;
    end else begin
      state_next.count = state_reg.count + TW'(1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign done = state_reg.done;

endmodule : delay_timer

// ===== verif/two_cell_protection_fsm_properties.sv
// Port-level checks of the protection state logic, bound to its top module
`timescale 1ns/1ps
module two_cell_protection_fsm_properties
  import prot_pkg::*;
#(
  parameter int OC_DET_CYC  = CYC_OC_DET,
  parameter int OD_DET_CYC  = CYC_OD_DET,
  parameter int EDC_DET_CYC = CYC_EDC_DET,
  parameter int SC_DET_CYC  = CYC_SC_DET,
  parameter int ECC_DET_CYC = CYC_ECC_DET,
  parameter int DS_DIV      = DS_DIV_DEF
) (
  input wire logic      core_clk,
  input wire logic      reset,
  input wire pin_in_t   pins_in,
  input wire gate_out_t gates_out
);
  // Test mode may cut detect delays down to this, so early checks use it
  localparam int OD_MIN = (OD_DET_CYC >= DS_DIV) ? OD_DET_CYC / DS_DIV : 1;
  localparam int OC_MIN = (OC_DET_CYC >= DS_DIV) ? OC_DET_CYC / DS_DIV : 1;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);
  logic cg, dg, pd, sb, und, ovr, rel, on2, od_hit;
  int   od_n, oc_n, ed_n, sc_n, ec_n;
  assign {cg, dg, pd, sb} = gates_out;
  assign und = pins_in.upper_cell_underv_detector || pins_in.lower_cell_underv_detector;
  assign ovr = pins_in.upper_cell_overv_detector || pins_in.lower_cell_overv_detector;
  assign rel = pins_in.charger_present && !und && !ovr;
  assign on2 = cg && dg;
  // Charger or a dead charge gate may legally hold off the under-voltage cut
  assign od_hit = od_n == OD_DET_CYC + 2 && !pins_in.charger_present && cg;
  // Pin runs, under-voltage only while pull-down is off; current runs only count while both gates are on
  always_ff @(posedge core_clk) begin
    od_n <= (!reset && und && !pd) ? od_n + 1 : 0;
    oc_n <= (!reset && ovr) ? oc_n + 1 : 0;
    ed_n <= (!reset && on2 && pins_in.discharge_overcurrent_detector) ? ed_n + 1 : 0;
    sc_n <= (!reset && on2 && pins_in.short_detector) ? sc_n + 1 : 0;
    ec_n <= (!reset && on2 && pins_in.charge_overcurrent_detector) ? ec_n + 1 : 0;
  end
  a_od_detect: assert property (od_hit |-> ##[1:3] sb)
    else $error("standby missing after held under-voltage");
  a_od_early: assert property ($rose(sb) |-> od_n >= OD_MIN)
    else $error("under-voltage cut came too soon");
  a_release_now: assert property ((sb && rel) ##1 rel [*4] |=> !sb)
    else $error("charger with healthy cells did not release");
  a_edc_fire: assert property (ed_n == EDC_DET_CYC + 2 |-> ##[1:3] pd)
    else $error("overload not latched after its delay");
  a_short_fire: assert property (sc_n == SC_DET_CYC + 2 |-> ##[1:3] !dg)
    else $error("short did not cut discharge after its delay");
  a_cur_early: assert property ($rose(pd) |-> sc_n >= SC_DET_CYC || ed_n >= EDC_DET_CYC)
    else $error("current fault latched early or with a gate off");
  a_ecc_fire: assert property (ec_n == ECC_DET_CYC + 2 |-> ##[1:3] !cg)
    else $error("charge overcurrent did not cut charge");
  a_chg_early: assert property ($fell(cg) |->
    ec_n >= ECC_DET_CYC || oc_n >= OC_MIN || pins_in.cell_at_zero)
    else $error("charge gate dropped without a filtered cause");
  a_pd_gate: assert property (pd |-> !dg)
    else $error("pull-down on while discharge gate on");
  a_standby_gate: assert property (sb |-> !dg)
    else $error("standby requested with discharge on");
  c_od: cover property ($rose(sb));
  c_cur: cover property ($rose(pd));
  c_chg: cover property ($fell(cg));
endmodule : two_cell_protection_fsm_properties

bind two_cell_protection_fsm two_cell_protection_fsm_properties #(
  .OC_DET_CYC (OC_DET_CYC),
  .OD_DET_CYC (OD_DET_CYC),
  .EDC_DET_CYC(EDC_DET_CYC),
  .SC_DET_CYC (SC_DET_CYC),
  .ECC_DET_CYC(ECC_DET_CYC),
  .DS_DIV     (DS_DIV)
) chk_u (
  .core_clk (core_clk),
  .reset    (reset),
  .pins_in  (pins_in),
  .gates_out(gates_out)
);

// ===== verif/pack_model.sv
// Pack-side model: cells, charger and load as the comparators see them
`timescale 1ns/1ps
module pack_model
  import prot_pkg::*;
(
  input  wire pin_in_t   scene,
  input  wire gate_out_t gates_out,
  output pin_in_t        pins_in
);
  logic held;
  // A load left on a cut-off pack drags the load pin to the top rail, past the short level
  assign held = !gates_out.discharge_gate_on && scene.discharge_overcurrent_detector;
  always_comb begin
    pins_in = scene;
    pins_in.short_detector = scene.short_detector || held;
  end
endmodule : pack_model

// ===== verif/two_cell_protection_fsm_bench.sv
// Directed bench for the two-cell protection state logic
`timescale 1ns/1ps
module two_cell_protection_fsm_bench;
  import prot_pkg::*;
  // Short delays keep the run brief; every expectation derives from these
  localparam int OC = 20, OCR = 5, OD = 30, ODR = 6, ED = 20, EDR = 6, SC = 8, EC = 16, ECR = 6;
  localparam logic [3:0] NORM = 4'hC, ODG = 4'h9, EDG = 4'hA, CHG = 4'h4;
  logic      core_clk;
  logic      reset;
  pin_in_t   scene;
  pin_in_t   pins_in;
  pin_in_t   p;
  gate_out_t gates_out;
  int        fail_count;
  int        n_tests;

  two_cell_protection_fsm #(
    .OC_DET_CYC(OC), .OC_REL_CYC(OCR), .OD_DET_CYC(OD), .OD_REL_CYC(ODR),
    .EDC_DET_CYC(ED), .EDC_REL_CYC(EDR), .SC_DET_CYC(SC), .ECC_DET_CYC(EC),
    .ECC_REL_CYC(ECR)
  ) dut_u (
    .core_clk (core_clk),
    .reset    (reset),
    .pins_in  (pins_in),
    .gates_out(gates_out)
  );
  pack_model model_u (
    .scene    (scene),
    .gates_out(gates_out),
    .pins_in  (pins_in)
  );

  always #2.5 core_clk = ~core_clk;

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : summarize

  // Apply the staged pin picture on the next rising edge
  task automatic put();
    @(posedge core_clk);
    scene <= p;
  endtask : put

  // Wait n edges, then compare all four gate outputs once settled
  task automatic go(input int n, input logic [3:0] exp);
    repeat (n) @(posedge core_clk);
    #1;
    n_tests++;
    if (gates_out !== exp) begin
      fail_count++;
      $display("CHECK FAILED gates_out expected %h seen %h at %0t", exp, gates_out, $time);
    end
  endtask : go

  // Hang guard, far beyond the few hundred cycles the run needs
  initial begin
    repeat (5000) @(posedge core_clk);
    fail_count++;
    summarize();
  end

  initial begin
    core_clk = 1'b0;
    reset = 1'b1;
    fail_count = 0;
    n_tests = 0;
    p = '0;
    p.pack_above_underv = 1'h1;
    p.upper_cell_release_ok = 1'h1;
    p.lower_cell_release_ok = 1'h1;
    p.version_sel = 2'h1;
    scene = p;
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    go(1, NORM);
    // A dip shorter than the detect delay is forgotten
    p.lower_cell_underv_detector = 1'h1;
    put();
    go(OD / 2, NORM);
    p.lower_cell_underv_detector = 1'h0;
    put();
    go(OD, NORM);
    // Held under-voltage cuts discharge and asks for standby
    p.upper_cell_underv_detector = 1'h1;
    put();
    go(OD + 1, NORM);
    go(4, ODG);
    // Charger with both cells recovered releases at once
    p.upper_cell_underv_detector = 1'h0;
    p.charger_present = 1'h1;
    p.lower_cell_overv_detector = 1'h1;
    put();
    go(5, ODG);
    p.lower_cell_overv_detector = 1'h0;
    put();
    go(5, NORM);
    p.charger_present = 1'h0;
    // Test voltage on the load pin shortens the detect delay
    p.delay_shorten_test = 1'h1;
    p.upper_cell_underv_detector = 1'h1;
    put();
    go(6, ODG);
    // Charger lifts the pack supply while the cell is still low
    p.delay_shorten_test = 1'h0;
    p.charger_present = 1'h1;
    put();
    go(ODR + 5, NORM);
    p.charger_present = 1'h0;
    p.upper_cell_underv_detector = 1'h0;
    put();
    // Dead short: fast cut-off, pull-down on, back on once the load is gone
    p.discharge_overcurrent_detector = 1'h1;
    p.short_detector = 1'h1;
    put();
    go(SC + 1, NORM);
    go(4, EDG);
    p.discharge_overcurrent_detector = 1'h0;
    p.short_detector = 1'h0;
    put();
    go(EDR + 1, EDG);
    go(4, NORM);
    // Overload shorter than its delay leaves discharge on
    p.discharge_overcurrent_detector = 1'h1;
    put();
    go(ED / 2, NORM);
    p.discharge_overcurrent_detector = 1'h0;
    put();
    go(ED, NORM);
    // Overload and under-voltage together end as overload
    p.discharge_overcurrent_detector = 1'h1;
    p.lower_cell_underv_detector = 1'h1;
    put();
    go(ED + 1, NORM);
    go(4, EDG);
    go(OD, EDG);
    p.discharge_overcurrent_detector = 1'h0;
    p.lower_cell_underv_detector = 1'h0;
    put();
    go(EDR + 5, NORM);
    // Charge overcurrent: filtered, latched, freed only by a load without charger
    p.charger_present = 1'h1;
    p.charge_overcurrent_detector = 1'h1;
    put();
    go(EC / 2, NORM);
    p.charge_overcurrent_detector = 1'h0;
    put();
    go(EC, NORM);
    p.charge_overcurrent_detector = 1'h1;
    put();
    go(EC + 5, CHG);
    p.charge_overcurrent_detector = 1'h0;
    put();
    go(ECR + 5, CHG);
    p.charger_present = 1'h0;
    p.discharge_overcurrent_detector = 1'h1;
    put();
    go(ECR + 5, NORM);
    p.discharge_overcurrent_detector = 1'h0;
    p.cell_at_zero = 1'h1;
    put();
    go(5, CHG);
    p.zero_charge_ok = 1'h1;
    put();
    go(5, NORM);
    p.cell_at_zero = 1'h0;
    // Over-charge latches and dominates a later under-voltage
    p.upper_cell_overv_detector = 1'h1;
    put();
    go(OC + 5, CHG);
    p.lower_cell_underv_detector = 1'h1;
    put();
    go(OD + 5, CHG);
    p.lower_cell_underv_detector = 1'h0;
    p.upper_cell_overv_detector = 1'h0;
    p.discharge_overcurrent_detector = 1'h1;
    put();
    go(OCR + 5, NORM);
    // Hysteresis variant: cells above release voltage free it without charger
    p.discharge_overcurrent_detector = 1'h0;
    p.version_sel = 2'h0;
    @(posedge core_clk);
    reset <= 1'b1;
    scene <= p;
    repeat (10) @(posedge core_clk);
    reset <= 1'b0;
    p.upper_cell_underv_detector = 1'h1;
    p.upper_cell_release_ok = 1'h0;
    put();
    go(OD + 5, ODG);
    p.upper_cell_underv_detector = 1'h0;
    p.upper_cell_release_ok = 1'h1;
    put();
    go(ODR + 1, ODG);
    go(4, NORM);
    summarize();
  end
endmodule : two_cell_protection_fsm_bench
